//--- logic/pwmisc_top.sv
// PWM generator control register with interrupt status and enables
// Functional notes
// - Fault pending flag sits in bit 15, set while a fault is pending.
// - Fault enable bit 12 allows fault interrupts; writing 0 clears flag.
// - Current-limit pending flag in bit 14 shows pending current-limit.
// - Writing current-limit enable to 0 clears its pending flag.
// - Trigger pending flag in bit 13 shows pending trigger interrupt.
// - Writing trigger enable to 0 clears its pending flag.
// - Current-limit enable at 1 allows, at 0 blocks those interrupts.
`timescale 1ns/1ps
module pwmisc_top (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire pwmisc_pkg::pwmisc_req_t req_in,
	output logic [pwmisc_pkg::DATA_W-1:0] rdata_out,
	input wire pwmisc_pkg::pwmisc_event_t event_in,
	output logic [5:0] remap_pin_output_function_out,
	output logic [pwmisc_pkg::DATA_W-1:0] pwm_generator_control_out,
	output logic pwm_irq_out,
	output logic irq_out
);
	import pwmisc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Registers and wires
	logic [DATA_W-1:0] control;
	logic [DATA_W-1:0] out_sel7;
	logic [EVENT_W-1:0] irq_status;
	logic [EVENT_W-1:0] irq_mask;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic [EVENT_W-1:0] pend;
	logic [EVENT_W-1:0] enables;
	logic [EVENT_W-1:0] clears;
	logic [EVENT_W-1:0] raw_events;
	logic [EVENT_W-1:0] rise;
	logic [EVENT_W-1:0] pend_d;
	logic [EVENT_W-1:0] status_w1c;
	logic wr_control;
	logic wr_sel7;
	logic wr_status;
	logic wr_mask;
	logic [DATA_W-1:0] control_view;

	// Address decode for the write strobe
	assign wr_control = req_in.wr & (req_in.addr == OFS_CONTROL);
	assign wr_sel7 = req_in.wr & (req_in.addr == OFS_OUT_SEL7);
	assign wr_status = req_in.wr & (req_in.addr == OFS_IRQ_STATUS);
	assign wr_mask = req_in.wr & (req_in.addr == OFS_IRQ_MASK);

	////////////////////////////////////////////////////////////////////
	// Enables come from the stored control word
	assign enables = {control[BIT_FLT_EN], control[BIT_CL_EN],
		control[BIT_TRG_EN]};
	assign raw_events = {event_in.fault, event_in.current_limit,
		event_in.trigger};

	// A write that leaves an enable at zero clears its flag
	assign clears[2] = wr_control & ~req_in.wdata[BIT_FLT_EN];
	assign clears[1] = wr_control & ~req_in.wdata[BIT_CL_EN];
	assign clears[0] = wr_control & ~req_in.wdata[BIT_TRG_EN];

	// Pending flags, one instance each, ordered fault, limit, trigger
	genvar gi;
	generate
		for (gi = 0; gi < EVENT_W; gi++) begin : g_flag
			pwmisc_flag u_flag (
				.sys_clk_in(sys_clk_in),
				.reset_n_in(reset_n_in),
				.event_in(raw_events[gi]),
				.enable_in(enables[gi]),
				.clear_in(clears[gi]),
				.pending_out(pend[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Control view: flags replace the stored top bits on read
	assign control_view = {pend[2], pend[1], pend[0],
		control[BIT_FLT_EN:0]};

	// Control and pin select storage; flag bits are not writable
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			control <= RESET_VALUE;
			out_sel7 <= RESET_VALUE;
		end else begin
			if (wr_control) begin
				control <= req_in.wdata & CONTROL_WMASK;
			end
			if (wr_sel7) begin
				out_sel7 <= req_in.wdata & OUT_SEL7_WMASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sticky status sees a rising pending flag; set wins over clear
	assign rise = pend & ~pend_d;
	assign status_w1c = wr_status ? req_in.wdata[EVENT_W-1:0] : EVENT_ZERO;

	// Status, mask and edge history
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			irq_status <= EVENT_ZERO;
			irq_mask <= EVENT_ZERO;
			pend_d <= EVENT_ZERO;
		end else begin
			pend_d <= pend;
			irq_status <= rise | (irq_status & ~status_w1c);
			if (wr_mask) begin
				irq_mask <= req_in.wdata[EVENT_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = RESET_VALUE;
		unique case (req_in.addr)
			OFS_CONTROL: next_rdata = control_view;
			OFS_OUT_SEL7: next_rdata = out_sel7;
			OFS_IRQ_STATUS: next_rdata = {13'h0000, irq_status};
			OFS_IRQ_MASK: next_rdata = {13'h0000, irq_mask};
			default: next_rdata = RESET_VALUE;
		endcase
	end

	// Read data registered, valid only the cycle after the strobe
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			rdata <= RESET_VALUE;
		end else begin
			rdata <= req_in.rd ? next_rdata : RESET_VALUE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign rdata_out = rdata;
	assign remap_pin_output_function_out = out_sel7[13:8];
	assign pwm_generator_control_out = control_view;
	assign pwm_irq_out = |(pend & enables);
	assign irq_out = |(irq_status & irq_mask);
endmodule // pwmisc_top

//--- logic/pwmisc_pkg.sv
// Package for the PWM generator interrupt status and control block
package pwmisc_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_OUT_SEL7 = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h3;
	localparam int unsigned BIT_FLT_PEND = 15;
	localparam int unsigned BIT_CL_PEND = 14;
	localparam int unsigned BIT_TRG_PEND = 13;
	localparam int unsigned BIT_FLT_EN = 12;
	localparam int unsigned BIT_CL_EN = 11;
	localparam int unsigned BIT_TRG_EN = 10;
	localparam logic [DATA_W-1:0] CONTROL_WMASK = 16'h1ff7;
	localparam logic [DATA_W-1:0] OUT_SEL7_WMASK = 16'h3f00;
	localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
	localparam int unsigned EVENT_W = 3;
	localparam logic [EVENT_W-1:0] EVENT_ZERO = 3'h0;

	// One request from the register port
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pwmisc_req_t;

	// Event group, ordered fault, current limit, trigger
	typedef struct packed {
		logic fault;
		logic current_limit;
		logic trigger;
	} pwmisc_event_t;
endpackage

//--- logic/pwmisc_flag.sv
// One sticky pending flag with enable gating and clear on disable
`timescale 1ns/1ps
module pwmisc_flag (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic event_in,
	input wire logic enable_in,
	input wire logic clear_in,
	output logic pending_out
);
	import pwmisc_pkg::*;
	logic pending;
	logic next_pending;

	// Set wins over clear so an event in the clearing cycle survives
	assign next_pending = (event_in & enable_in) | (pending & ~clear_in);
	assign pending_out = pending;

	// Flag register, zero after reset
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			pending <= 1'b0;
		end else begin
			pending <= next_pending;
		end
	end
endmodule // pwmisc_flag

//--- verification/pwmisc_assertions.sv
// Checker for the PWM interrupt status and enable block
`timescale 1ns/1ps
module pwmisc_chk (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire pwmisc_pkg::pwmisc_req_t req_in,
	input wire pwmisc_pkg::pwmisc_event_t event_in,
	input wire logic [15:0] pwm_generator_control_out,
	input wire logic pwm_irq_out
);
	import pwmisc_pkg::*;
	// Short views: flags and enables, events, control write decode
	wire [15:0] c = pwm_generator_control_out;
	wire [2:0] e = event_in;
	wire w = req_in.wr && req_in.addr == OFS_CONTROL;
	wire [2:0] d = req_in.wdata[12:10];
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////////////////////////////////////////////
	// Events are blocked (!e) in clears because set wins over clear
	chk_fault_set: assert property (e[2] && c[12] |=> c[15])
		else $error("fault flag not set");
	chk_fault_clr: assert property (w && !d[2] && !e[2] |=> !c[15])
		else $error("fault flag not cleared");
	chk_limit_set: assert property (e[1] && c[11] |=> c[14])
		else $error("limit flag not set");
	chk_limit_clr: assert property (w && !d[1] && !e[1] |=> !c[14])
		else $error("limit flag not cleared");
	chk_trig_set: assert property (e[0] && c[10] |=> c[13])
		else $error("trigger flag not set");
	chk_trig_clr: assert property (w && !d[0] && !e[0] |=> !c[13])
		else $error("trigger flag not cleared");
	chk_limit_gate: assert property (!c[11] && !c[14] |=> !c[14])
		else $error("disabled limit set flag");
	chk_irq_level: assert property (
		pwm_irq_out == |(c[15:13] & c[12:10]))
		else $error("request level wrong");
	chk_reset_zero: assert property (disable iff (1'b0)
		!reset_n_in |=> c == 16'h0) else $error("reset value wrong");
	// Main scenarios reached
	cover property (w && !d[2] && c[15]);
	cover property (e[2] && c[12]);
	cover property (pwm_irq_out);
endmodule // pwmisc_chk

bind pwmisc_top pwmisc_chk u_chk (.sys_clk_in(sys_clk_in),
	.reset_n_in(reset_n_in), .req_in(req_in), .event_in(event_in),
	.pwm_generator_control_out(pwm_generator_control_out),
	.pwm_irq_out(pwm_irq_out));

//--- verification/pwmisc_tb.sv
// Self-checking bench for the PWM interrupt status and enable block
`timescale 1ns/1ps
module testbench;
	import pwmisc_pkg::*;
	logic sys_clk_in = 0;
	logic reset_n_in = 0;
	pwmisc_req_t req_in = '0;
	pwmisc_event_t event_in = '0;
	logic [15:0] rdata_out, ctl;
	logic [5:0] sel;
	logic pirq, irq_out;
	int n_mismatch = 0, comparisons = 0;
	// Rows: events, enables, expected flags, three bits each
	logic [8:0] rows [7] = '{9'h13c, 9'h118, 9'h092, 9'h0a8, 9'h049, 9'h070,
		9'h1ff};
	always #50 sys_clk_in = ~sys_clk_in;
	pwmisc_top dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.req_in(req_in), .rdata_out(rdata_out), .event_in(event_in),
		.remap_pin_output_function_out(sel), .pwm_generator_control_out(ctl),
		.pwm_irq_out(pirq), .irq_out(irq_out));
	////////////////////////////////////////////////////////////////////////
	// Compare, bus cycles and event pulse
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		req_in <= '{a, v, 1'b1, 1'b0};
		@(posedge sys_clk_in);
		req_in <= '0;
		@(posedge sys_clk_in);
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] x);
		req_in <= '{a, 16'h0, 1'b0, 1'b1};
		@(posedge sys_clk_in);
		req_in <= '0;
		#1 chk(rdata_out, x);
		@(posedge sys_clk_in);
	endtask
	task automatic pulse(input logic [2:0] v);
		event_in <= v;
		@(posedge sys_clk_in);
		event_in <= '0;
		@(posedge sys_clk_in);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Hang guard, far beyond the roughly 140 cycles needed
	initial begin
		repeat (3000) @(posedge sys_clk_in);
		n_mismatch++;
		tally_and_finish;
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, table loop, then the awkward cases
	initial begin
		repeat (4) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		@(posedge sys_clk_in);
		#1 chk(ctl, 16'h0);
		wr(OFS_IRQ_MASK, 16'h7);
		foreach (rows[i]) begin
			wr(OFS_CONTROL, {3'h0, rows[i][5:3], 10'h0});
			pulse(rows[i][8:6]);
			chk(16'(pirq), 16'(|rows[i][2:0]));
			rd(OFS_CONTROL, {rows[i][2:0], rows[i][5:3], 10'h0});
			chk(16'(irq_out), 16'(|rows[i][2:0]));
			rd(OFS_IRQ_STATUS, {13'h0, rows[i][2:0]});
			wr(OFS_IRQ_STATUS, 16'h7);
			wr(OFS_CONTROL, 16'h0);
			rd(OFS_CONTROL, 16'h0);
		end
		// Mask hides a set status bit; write-one clears only that bit
		wr(OFS_IRQ_MASK, 16'h0);
		wr(OFS_CONTROL, 16'h1c00);
		pulse(3'h7);
		#1 chk(16'(irq_out), 16'h0);
		wr(OFS_IRQ_MASK, 16'h4);
		#1 chk(16'(irq_out), 16'h1);
		wr(OFS_IRQ_STATUS, 16'h4);
		rd(OFS_IRQ_STATUS, 16'h3);
		// Dropping one enable clears its own flag only
		wr(OFS_CONTROL, 16'h0c00);
		rd(OFS_CONTROL, 16'h6c00);
		wr(OFS_CONTROL, 16'h1000);
		rd(OFS_CONTROL, 16'h1000);
		wr(OFS_CONTROL, 16'he000);
		rd(OFS_CONTROL, 16'h0);
		wr(OFS_OUT_SEL7, 16'hffff);
		rd(OFS_OUT_SEL7, 16'h3f00);
		chk(16'(sel), 16'h003f);
		rd(4'hf, 16'h0);
		// Reset in mid-run with all flags set
		wr(OFS_CONTROL, 16'h1c00);
		pulse(3'h7);
		reset_n_in <= 1'b0;
		@(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		#1 chk(ctl, 16'h0);
		tally_and_finish;
	end
endmodule // testbench
